// ===== jic_chains.sv
`include "jic_params.svh"
`default_nettype none

module jic_chains
    import jic_pkg::*;
#(
    parameter int NPIN = `JIC_NPIN_DEF,
    parameter logic [`JIC_ID_W-1:0] ID_CODE = `JIC_ID_DEF
) (
    input wire logic ref_clk, // system clock
    input wire logic sys_rst, // synchronous reset, ref_clk domain
    input wire logic tck, // test clock from the tester
    input wire logic por, // power-on reset, asynchronous level
    input wire jic_tap_t tap, // tap state strobes, tck domain
    input wire logic tdi, // serial data in
    output logic tdo, // serial data out
    output logic tdo_oe, // tdo driven while high
    input wire logic [NPIN-1:0] pad_in, // levels arriving from pads
    output logic [NPIN-1:0] pad_out, // levels driven to pads
    output logic [NPIN-1:0] pad_oe, // pad output enables
    input wire logic [NPIN-1:0] core_out, // core output values
    input wire logic [NPIN-1:0] core_oe, // core output enables
    output logic [NPIN-1:0] core_in, // values handed to the core
    input wire logic ext_rst_pin_n, // external reset pin, low active
    output logic core_rst_n, // reset pin level seen by the core
    output logic dp_req_valid, // one-cycle debug request strobe
    output jic_dp_req_t dp_req, // debug request contents
    input wire logic dp_rsp_valid, // debug port answer strobe
    input wire logic [`JIC_DP_W-1:0] dp_rsp_data // debug port answer
);

    localparam int BSL = NPIN * `JIC_BS_CELLS + 1;
    localparam int RST_CELL = BSL - 1;

    // decode of the active instruction into a chain select
    function automatic jic_sel_t sel_of(input logic [`JIC_IR_W-1:0] ir);
        jic_sel_t s;
        s = JIC_SEL_BYP;
        unique case (ir)
            `JIC_IR_SAMPLE: s = JIC_SEL_BSC;
            `JIC_IR_ABORT,
            `JIC_IR_DP_ACCESS,
            `JIC_IR_AP_ACCESS: s = JIC_SEL_DP;
            `JIC_IR_IDCODE: s = JIC_SEL_ID;
            // extest and intest own no chain; they and all spare codes bypass
            default: s = JIC_SEL_BYP;
        endcase
        return s;
    endfunction : sel_of

    // which debug access a dp-chain instruction stands for
    function automatic jic_dp_kind_t kind_of(input logic [`JIC_IR_W-1:0] ir);
        jic_dp_kind_t k;
        k = JIC_DPK_AP;
        if (ir == `JIC_IR_ABORT) begin
            k = JIC_DPK_ABORT;
        end else if (ir == `JIC_IR_DP_ACCESS) begin
            k = JIC_DPK_DP;
        end
        return k;
    endfunction : kind_of

    // power-on reset synchroniser; the external reset pin never reaches here
    logic por_s1_q, por_s2_q;
    always_ff @(posedge tck) begin
        por_s1_q <= por;
        por_s2_q <= por_s1_q;
    end

    // pad and core levels brought into tck for capture
    logic [NPIN-1:0] tin_s1_q, tin_s2_q;
    logic [NPIN-1:0] tout_s1_q, tout_s2_q;
    logic [NPIN-1:0] toe_s1_q, toe_s2_q;
    logic trst_s1_q, trst_s2_q;
    always_ff @(posedge tck) begin
        tin_s1_q <= pad_in;
        tin_s2_q <= tin_s1_q;
        tout_s1_q <= core_out;
        tout_s2_q <= tout_s1_q;
        toe_s1_q <= core_oe;
        toe_s2_q <= toe_s1_q;
        trst_s1_q <= ext_rst_pin_n;
        trst_s2_q <= trst_s1_q;
    end

    // instruction shift chain and holding register
    logic [`JIC_IR_W-1:0] ir_sh_q, ir_q;
    always_ff @(posedge tck) begin
        if (por_s2_q || tap.tlr) begin
            ir_sh_q <= `JIC_IR_IDCODE;
            ir_q <= `JIC_IR_IDCODE;
        end else begin
            if (tap.cap_ir) begin
                ir_sh_q <= `JIC_IR_CAPTURE;
            end else if (tap.sh_ir) begin
                ir_sh_q <= {tdi, ir_sh_q[`JIC_IR_W-1:1]};
            end
            if (tap.upd_ir) begin
                ir_q <= ir_sh_q;
            end
        end
    end

    jic_sel_t sel;
    assign sel = sel_of(ir_q);

    // test modes registered so the crossing sees clean levels
    logic extest_q, intest_q;
    always_ff @(posedge tck) begin
        if (por_s2_q) begin
            extest_q <= 1'b0;
            intest_q <= 1'b0;
        end else begin
            extest_q <= (ir_q == `JIC_IR_EXTEST);
            intest_q <= (ir_q == `JIC_IR_INTEST);
        end
    end

    // bypass stage
    logic byp_q;
    always_ff @(posedge tck) begin
        if (por_s2_q) begin
            byp_q <= 1'b0;
        end else if (tap.cap_dr && sel == JIC_SEL_BYP) begin
            byp_q <= `JIC_BYP_CAPTURE;
        end else if (tap.sh_dr && sel == JIC_SEL_BYP) begin
            byp_q <= tdi;
        end
    end

    // identification chain; bit 0 forced to one whatever the parameter
    logic [`JIC_ID_W-1:0] id_sh_q;
    always_ff @(posedge tck) begin
        if (por_s2_q) begin
            id_sh_q <= '0;
        end else if (tap.cap_dr && sel == JIC_SEL_ID) begin
            id_sh_q <= {ID_CODE[`JIC_ID_W-1:1], 1'b1};
        end else if (tap.sh_dr && sel == JIC_SEL_ID) begin
            id_sh_q <= {tdi, id_sh_q[`JIC_ID_W-1:1]};
        end
    end

    // capture vector: per pin input, output, enable, then the reset cell
    logic [BSL-1:0] cap_vec;
    for (genvar p = 0; p < NPIN; p++) begin : g_cap
        assign cap_vec[p*`JIC_BS_CELLS+`JIC_BS_IN] = tin_s2_q[p];
        assign cap_vec[p*`JIC_BS_CELLS+`JIC_BS_OUT] = tout_s2_q[p];
        assign cap_vec[p*`JIC_BS_CELLS+`JIC_BS_OE] = toe_s2_q[p];
    end
    assign cap_vec[RST_CELL] = trst_s2_q;

    // boundary shift chain and its holding register
    logic [BSL-1:0] bsc_sh_q, bsc_hold_q;
    logic bh_tgl_q;
    always_ff @(posedge tck) begin
        if (por_s2_q) begin
            bsc_sh_q <= '0;
            bsc_hold_q <= '0;
            bh_tgl_q <= 1'b0;
        end else if (sel == JIC_SEL_BSC) begin
            if (tap.cap_dr) begin
                bsc_sh_q <= cap_vec;
            end else if (tap.sh_dr) begin
                bsc_sh_q <= {tdi, bsc_sh_q[BSL-1:1]};
            end
            if (tap.upd_dr) begin
                bsc_hold_q <= bsc_sh_q;
                bh_tgl_q <= ~bh_tgl_q;
            end
        end
    end

    // answer from the debug port crosses in by toggle; data is held stable
    logic [`JIC_DP_W-1:0] rsp_hold_q;
    logic rsp_tgl_q;
    logic rs_s1_q, rs_s2_q, rs_s3_q;
    logic [`JIC_DP_W-1:0] rsp_tck_q;
    always_ff @(posedge tck) begin
        if (por_s2_q) begin
            rs_s1_q <= 1'b0;
            rs_s2_q <= 1'b0;
            rs_s3_q <= 1'b0;
            rsp_tck_q <= '0;
        end else begin
            rs_s1_q <= rsp_tgl_q;
            rs_s2_q <= rs_s1_q;
            rs_s3_q <= rs_s2_q;
            if (rs_s2_q != rs_s3_q) begin
                rsp_tck_q <= rsp_hold_q;
            end
        end
    end

    // shared 35-bit shifter for the three debug access chains
    logic [`JIC_DP_W-1:0] dp_sh_q;
    jic_dp_req_t dq_q;
    logic dq_tgl_q;
    always_ff @(posedge tck) begin
        if (por_s2_q) begin
            dp_sh_q <= '0;
            dq_q <= '0;
            dq_tgl_q <= 1'b0;
        end else if (sel == JIC_SEL_DP) begin
            if (tap.cap_dr) begin
                // abort returns nothing; the others show the last answer
                if (ir_q == `JIC_IR_ABORT) begin
                    dp_sh_q <= '0;
                end else begin
                    dp_sh_q <= rsp_tck_q;
                end
            end else if (tap.sh_dr) begin
                dp_sh_q <= {tdi, dp_sh_q[`JIC_DP_W-1:1]};
            end
            if (tap.upd_dr) begin
                dq_q <= '{kind: kind_of(ir_q), payload: dp_sh_q};
                dq_tgl_q <= ~dq_tgl_q;
            end
        end
    end

    // select the serial source for tdo
    logic tdo_src;
    always_comb begin
        tdo_src = byp_q;
        if (tap.sh_ir) begin
            tdo_src = ir_sh_q[0];
        end else begin
            unique case (sel)
                JIC_SEL_ID: tdo_src = id_sh_q[0];
                JIC_SEL_BSC: tdo_src = bsc_sh_q[0];
                JIC_SEL_DP: tdo_src = dp_sh_q[0];
                JIC_SEL_BYP: tdo_src = byp_q;
            endcase
        end
    end

    // falling-edge output gives the tester half a period of setup
    logic tdo_q, tdo_oe_q;
    always_ff @(negedge tck) begin
        if (por_s2_q) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q <= tdo_src;
            tdo_oe_q <= tap.sh_ir || tap.sh_dr;
        end
    end
    assign tdo = tdo_q;
    assign tdo_oe = tdo_oe_q;

    // test mode levels into ref_clk
    logic ex_s1_q, ex_s2_q;
    logic in_s1_q, in_s2_q;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ex_s1_q <= 1'b0;
            ex_s2_q <= 1'b0;
            in_s1_q <= 1'b0;
            in_s2_q <= 1'b0;
        end else begin
            ex_s1_q <= extest_q;
            ex_s2_q <= ex_s1_q;
            in_s1_q <= intest_q;
            in_s2_q <= in_s1_q;
        end
    end

    // preload word crosses by toggle; it only changes once per full scan,
    // which is far longer than the three-flop handshake delay
    logic bh_s1_q, bh_s2_q, bh_s3_q;
    logic [BSL-1:0] bsc_ref_q;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bh_s1_q <= 1'b0;
            bh_s2_q <= 1'b0;
            bh_s3_q <= 1'b0;
            bsc_ref_q <= '0;
        end else begin
            bh_s1_q <= bh_tgl_q;
            bh_s2_q <= bh_s1_q;
            bh_s3_q <= bh_s2_q;
            if (bh_s2_q != bh_s3_q) begin
                bsc_ref_q <= bsc_hold_q;
            end
        end
    end

    // pad inputs and reset pin into ref_clk
    logic [NPIN-1:0] rin_s1_q, rin_s2_q;
    logic rrst_s1_q, rrst_s2_q;
    always_ff @(posedge ref_clk) begin
        rin_s1_q <= pad_in;
        rin_s2_q <= rin_s1_q;
        rrst_s1_q <= ext_rst_pin_n;
        rrst_s2_q <= rrst_s1_q;
    end

    // per-pin muxing between core and preloaded boundary values
    for (genvar p = 0; p < NPIN; p++) begin : g_pin
        logic po_q;
        logic poe_q;
        logic ci_q;
        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                po_q <= 1'b0;
                poe_q <= 1'b0;
                ci_q <= 1'b0;
            end else begin
                po_q <= ex_s2_q ?
                    bsc_ref_q[p*`JIC_BS_CELLS+`JIC_BS_OUT] : core_out[p];
                poe_q <= ex_s2_q ?
                    bsc_ref_q[p*`JIC_BS_CELLS+`JIC_BS_OE] : core_oe[p];
                ci_q <= in_s2_q ?
                    bsc_ref_q[p*`JIC_BS_CELLS+`JIC_BS_IN] : rin_s2_q[p];
            end
        end
        assign pad_out[p] = po_q;
        assign pad_oe[p] = poe_q;
        assign core_in[p] = ci_q;
    end

    // reset pin cell also feeds the core under intest
    logic core_rst_n_q;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            core_rst_n_q <= 1'b0;
        end else begin
            core_rst_n_q <= in_s2_q ? bsc_ref_q[RST_CELL] : rrst_s2_q;
        end
    end
    assign core_rst_n = core_rst_n_q;

    // debug request arrives by toggle and leaves as a one-cycle strobe
    logic dq_s1_q, dq_s2_q, dq_s3_q;
    logic dp_req_valid_q;
    jic_dp_req_t dp_req_q;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dq_s1_q <= 1'b0;
            dq_s2_q <= 1'b0;
            dq_s3_q <= 1'b0;
            dp_req_valid_q <= 1'b0;
            dp_req_q <= '0;
        end else begin
            dq_s1_q <= dq_tgl_q;
            dq_s2_q <= dq_s1_q;
            dq_s3_q <= dq_s2_q;
            dp_req_valid_q <= (dq_s2_q != dq_s3_q);
            if (dq_s2_q != dq_s3_q) begin
                dp_req_q <= dq_q;
            end
        end
    end
    assign dp_req_valid = dp_req_valid_q;
    assign dp_req = dp_req_q;

    // answer is held here until the next one; answers must not come
    // faster than the tck side can sample the toggle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rsp_hold_q <= '0;
            rsp_tgl_q <= 1'b0;
        end else if (dp_rsp_valid) begin
            rsp_hold_q <= dp_rsp_data;
            rsp_tgl_q <= ~rsp_tgl_q;
        end
    end

endmodule : jic_chains

`default_nettype wire

// ===== jic_params.svh
`ifndef JIC_PARAMS_SVH
`define JIC_PARAMS_SVH

// instruction register width and codes
`define JIC_IR_W 4
`define JIC_IR_EXTEST 4'h0
`define JIC_IR_INTEST 4'h1
`define JIC_IR_SAMPLE 4'h2
`define JIC_IR_ABORT 4'h8
`define JIC_IR_DP_ACCESS 4'hA
`define JIC_IR_AP_ACCESS 4'hB
`define JIC_IR_IDCODE 4'hE
`define JIC_IR_BYPASS 4'hF
// value parked in the instruction chain at capture
`define JIC_IR_CAPTURE 4'h1

// chain lengths and the bypass capture value
`define JIC_ID_W 32
`define JIC_DP_W 35
`define JIC_BYP_CAPTURE 1'h0

// boundary cell layout per pin
`define JIC_BS_CELLS 3
`define JIC_BS_IN 0
`define JIC_BS_OUT 1
`define JIC_BS_OE 2

// defaults for module parameters; the id value is arbitrary
`define JIC_NPIN_DEF 8
`define JIC_ID_DEF 32'h1234_5679

`endif

// ===== jic_pkg.sv
`include "jic_params.svh"
`default_nettype none

package jic_pkg;

    // strobes from the tap state machine, all in the test clock domain
    typedef struct packed {
        logic tlr;     // test-logic-reset state
        logic cap_ir;  // capture-ir state
        logic sh_ir;   // shift-ir state
        logic upd_ir;  // update-ir state
        logic cap_dr;  // capture-dr state
        logic sh_dr;   // shift-dr state
        logic upd_dr;  // update-dr state
    } jic_tap_t;

    // which data chain sits between tdi and tdo
    typedef enum logic [1:0] {
        JIC_SEL_BYP = 2'b00,
        JIC_SEL_ID = 2'b01,
        JIC_SEL_BSC = 2'b10,
        JIC_SEL_DP = 2'b11
    } jic_sel_t;

    // kind of debug access port request
    typedef enum logic [1:0] {
        JIC_DPK_ABORT = 2'b00,
        JIC_DPK_DP = 2'b01,
        JIC_DPK_AP = 2'b10
    } jic_dp_kind_t;

    // request handed to the debug access port
    typedef struct packed {
        jic_dp_kind_t kind;
        logic [`JIC_DP_W-1:0] payload;
    } jic_dp_req_t;

endpackage : jic_pkg

`default_nettype wire

// ===== jic_chains_assertions.sv
`default_nettype none
module jic_chains_checker
    import jic_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic sys_rst, // system reset
    input wire logic tck, // test clock
    input wire logic por, // power-on reset
    input wire jic_tap_t tap, // tap strobes
    input wire logic tdo, // serial out
    input wire logic tdo_oe, // serial out enable
    input wire logic dp_req_valid, // request strobe
    input wire jic_dp_req_t dp_req // request contents
);
    timeunit 1ns;
    timeprecision 100ps;
    logic tdo_pos_q;

    // tdo as it stood at the rising edge, so a mid-cycle change shows up
    always_ff @(posedge tck) begin
        tdo_pos_q <= tdo;
    end

    oe_shift_a: assert property (@(posedge tck) disable iff (por)
        tdo_oe == (tap.sh_ir || tap.sh_dr)) else $error("tdo enable wrong");
    tdo_edge_a: assert property (@(negedge tck) disable iff (por)
        tdo == tdo_pos_q) else $error("tdo moved on rising edge");
    por_clear_a: assert property (@(posedge tck) disable iff (por)
        $fell(por) |-> !tdo_oe && !tdo) else $error("tdo not cleared");
    ir_cap_a: assert property (@(posedge tck) disable iff (por)
        tap.cap_ir ##1 tap.sh_ir |-> tdo) else $error("ir capture bit0");
    ir_cap_hi_a: assert property (@(posedge tck) disable iff (por)
        tap.cap_ir ##1 tap.sh_ir [*2] |-> !tdo) else $error("ir capture bit1");
    idc_tlr_a: assert property (@(posedge tck) disable iff (por)
        tap.tlr ##1 tap.cap_dr ##1 tap.sh_dr |-> tdo)
        else $error("no identification after reset");
    req_pulse_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst) dp_req_valid |=> !dp_req_valid)
        else $error("request too long");
    req_hold_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst) !dp_req_valid |-> $stable(dp_req))
        else $error("request moved");
    req_kind_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst) dp_req_valid |-> dp_req.kind inside
        {JIC_DPK_ABORT, JIC_DPK_DP, JIC_DPK_AP})
        else $error("bad request kind");

    // main scenarios reached
    c_req: cover property (@(posedge ref_clk) dp_req_valid);
    c_upd: cover property (@(posedge tck) tap.upd_dr);
    c_ir: cover property (@(posedge tck) tap.cap_ir ##1 tap.sh_ir);
endmodule : jic_chains_checker

bind jic_chains jic_chains_checker u_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .tck(tck), .por(por), .tap(tap),
    .tdo(tdo), .tdo_oe(tdo_oe), .dp_req_valid(dp_req_valid),
    .dp_req(dp_req)
);
`default_nettype wire

// ===== jic_tester.sv
`default_nettype none
module jic_tester
    import jic_pkg::*;
(
    output var logic tck, // test clock, still between scans
    output var jic_tap_t tap, // tap state strobes
    output var logic tdi, // serial data to device
    input wire logic tdo // serial data from device
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        tck = 1'b0;
        tdi = 1'b0;
        tap = '0;
    end

    // one 12 ns period; tdo is taken just before the rising edge
    task automatic clk(output logic o);
        #5 tck = 1'b0;
        #6 o = tdo;
        tck = 1'b1;
        #1;
    endtask : clk

    task automatic run(input int n);
        logic d;
        repeat (n) clk(d);
    endtask : run

    // strobes change 1 ns after the rising edge, as a controller would;
    // tlr stands until the next scan replaces it in one assignment
    task automatic reset(input int n);
        tap = '{tlr: 1'b1, default: 1'b0};
        run(n);
    endtask : reset

    // capture, n shifts lsb first, update, one idle period
    task automatic scan(input logic ir, input int n, input logic [39:0] din,
            output logic [39:0] dout);
        logic d;
        dout = '0;
        tap = '{cap_ir: ir, cap_dr: !ir, default: 1'b0};
        run(1);
        for (int i = 0; i < n; i++) begin
            tap = '{sh_ir: ir, sh_dr: !ir, default: 1'b0};
            tdi = din[i];
            clk(d);
            dout[i] = d;
        end
        tap = '{upd_ir: ir, upd_dr: !ir, default: 1'b0};
        run(1);
        tap = '0;
        tdi = !tdi; // idle line keeps moving so a stale bit is not trusted
        run(1);
    endtask : scan
endmodule : jic_tester
`default_nettype wire

// ===== tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NP = 8;
    localparam int BW = 3 * NP + 1;
    localparam logic [31:0] TB_ID = 32'h0F0F_5A5A; // arbitrary value
    localparam logic [39:0] PL = 40'h00_00C3_5A69;
    localparam logic [7:0] BY = 8'hB4;
    logic ref_clk = 1'b0;
    logic sys_rst, por, tdo, tdo_oe, ext_rst_pin_n, core_rst_n;
    logic dp_req_valid, dp_rsp_valid;
    logic [NP-1:0] pad_in, pad_out, pad_oe, core_out, core_oe, core_in;
    logic [34:0] dp_rsp_data;
    wire logic tck, tdi;
    wire jic_pkg::jic_tap_t tap;
    jic_pkg::jic_dp_req_t dp_req, req_q;
    int failures = 0, checked = 0, req_cnt = 0;

    always #20 ref_clk = ~ref_clk;

    // keep the last request, since its strobe lasts one cycle
    always @(posedge ref_clk) begin
        if (dp_req_valid === 1'b1) begin
            req_cnt++;
            req_q = dp_req;
        end
    end

    jic_chains #(.NPIN(NP), .ID_CODE(TB_ID)) DUT (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .tck(tck), .por(por), .tap(tap), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .core_out(core_out), .core_oe(core_oe),
        .core_in(core_in), .ext_rst_pin_n(ext_rst_pin_n),
        .core_rst_n(core_rst_n), .dp_req_valid(dp_req_valid),
        .dp_req(dp_req), .dp_rsp_valid(dp_rsp_valid),
        .dp_rsp_data(dp_rsp_data));
    // a released tdo shows the inverse, so a missing enable is caught
    jic_tester tester (.tck(tck), .tap(tap), .tdi(tdi),
        .tdo(tdo_oe ? tdo : ~tdo));

    task automatic chk(input logic [39:0] got, input logic [39:0] exp,
            input string what);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h", $time, what, got);
        end
    endtask : chk

    task automatic wrap_up;
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    task automatic t_idcode;
        logic [39:0] d;
        tester.scan(1'b0, 32, 40'h0, d);
        chk(d, TB_ID | 32'h1, "idcode");
        tester.scan(1'b1, 4, 40'hE, d);
        chk(d, 40'h1, "ir capture");
    endtask : t_idcode

    // capture with reset pin low, then leave a preload behind
    task automatic t_sample;
        logic [39:0] d, e;
        @(posedge ref_clk);
        #1 pad_in = 8'h96;
        core_out = 8'hA5;
        core_oe = 8'h3C;
        ext_rst_pin_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        tester.scan(1'b1, 4, 40'h2, d);
        tester.scan(1'b0, BW, PL, d);
        e = '0;
        for (int p = 0; p < NP; p++) begin
            e[3*p] = pad_in[p];
            e[3*p+1] = core_out[p];
            e[3*p+2] = core_oe[p];
        end
        chk(d, e, "boundary capture");
        ext_rst_pin_n = 1'b1;
    endtask : t_sample

    task automatic t_pads;
        logic [39:0] d;
        logic [NP-1:0] eo, ee, ei;
        for (int p = 0; p < NP; p++) begin
            ei[p] = PL[3*p];
            eo[p] = PL[3*p+1];
            ee[p] = PL[3*p+2];
        end
        tester.scan(1'b1, 4, 40'h0, d);
        repeat (8) @(posedge ref_clk);
        #1 chk(pad_out, eo, "extest out");
        chk(pad_oe, ee, "extest oe");
        chk(core_in, pad_in, "extest core");
        chk(core_rst_n, 1'b1, "extest reset pin");
        tester.scan(1'b1, 4, 40'h1, d);
        repeat (8) @(posedge ref_clk);
        #1 chk(core_in, ei, "intest in");
        chk(core_rst_n, PL[BW-1], "intest reset cell");
        chk(pad_out, core_out, "intest pads");
        chk(pad_oe, core_oe, "intest oe");
    endtask : t_pads

    task automatic t_bypass;
        logic [39:0] d;
        logic [3:0] cd [11] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
            4'h9, 4'hC, 4'hD, 4'hF};
        foreach (cd[k]) begin
            tester.scan(1'b1, 4, {36'h0, cd[k]}, d);
            tester.scan(1'b0, 8, BY, d);
            chk(d, {BY[6:0], 1'b0}, "bypass");
        end
        @(posedge ref_clk);
        #1 ext_rst_pin_n = 1'b0;
        tester.run(3);
        ext_rst_pin_n = 1'b1;
        tester.scan(1'b0, 8, BY, d);
        chk(d, {BY[6:0], 1'b0}, "pin reset kept ir");
    endtask : t_bypass

    task automatic t_debug;
        logic [39:0] d;
        logic [3:0] cd [3] = '{4'h8, 4'hA, 4'hB};
        logic [34:0] pay, rsp;
        int n0;
        foreach (cd[k]) begin
            pay = 35'h3_C0A5_0000 + cd[k];
            rsp = 35'h2_1357_9BDF ^ {31'h0, cd[k]};
            tester.scan(1'b1, 4, {36'h0, cd[k]}, d);
            n0 = req_cnt;
            tester.scan(1'b0, 35, {5'h0, pay}, d);
            for (int w = 0; w < 20 && req_cnt == n0; w++) @(posedge ref_clk);
            chk(40'(req_cnt - n0), 40'h1, "request count");
            chk(req_q.payload, pay, "request data");
            chk(req_q.kind, 40'(k), "request kind");
            @(posedge ref_clk);
            #1 dp_rsp_valid = 1'b1;
            dp_rsp_data = rsp;
            @(posedge ref_clk);
            #1 dp_rsp_valid = 1'b0;
            dp_rsp_data = ~rsp;
            tester.run(6);
            tester.scan(1'b0, 35, 40'h0, d);
            chk(d, cd[k] == 4'h8 ? 35'h0 : rsp, "answer");
            repeat (8) @(posedge ref_clk);
        end
    endtask : t_debug

    task automatic t_tlr;
        logic [39:0] d;
        tester.reset(3);
        tester.scan(1'b0, 32, 40'h0, d);
        chk(d, TB_ID | 32'h1, "idcode after reset state");
    endtask : t_tlr

    initial begin
        sys_rst = 1'b1;
        por = 1'b1;
        pad_in = '0;
        core_out = '0;
        core_oe = '0;
        ext_rst_pin_n = 1'b1;
        dp_rsp_valid = 1'b0;
        dp_rsp_data = '0;
        repeat (6) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        tester.reset(5);
        por = 1'b0;
        tester.reset(4);
        t_idcode();
        t_sample();
        t_pads();
        t_bypass();
        t_debug();
        t_tlr();
        wrap_up();
    end

    // the whole run needs well under 50 us
    initial begin
        #200us;
        failures++;
        wrap_up();
    end
endmodule : tb
`default_nettype wire
